// [hdl/mse_pkg.sv]
// Purpose: constants shared by the soft-error monitor design
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: register offsets and layouts are local choices
package mse_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATE = 8'h04;
	localparam logic [7:0] OFS_INFO = 8'h08;
	localparam logic [7:0] OFS_INDEX = 8'h0C;
	localparam logic [7:0] OFS_DIVIDER = 8'h10;
	localparam logic [7:0] OFS_INJECT = 8'h14;

	// Control fields
	localparam int CTL_TRIGGER_BIT = 0;
	localparam int CTL_PCIE_WATCH_BIT = 1;

	// State register fields
	localparam int ST_IDLE_BIT = 0;
	localparam int ST_DETECT_BIT = 1;
	localparam int ST_WATCHING_BIT = 2;
	localparam int ST_BUSY_BIT = 3;
	localparam int ST_PENDING_BIT = 4;

	// Info register fields
	localparam int INF_UNCORR_BIT = 0;
	localparam int INF_UNCORR_LOST_BIT = 1;
	localparam int INF_CORR_BIT = 2;
	localparam int INF_CORR_LOST_BIT = 3;
	localparam int INF_ADDR_LSB = 4;

	// Reset values
	localparam logic [15:0] DIVIDER_RESET = 16'h00FF;

	// Response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MON_IDLE = 2'b00,
		MON_WATCHING = 2'b01,
		MON_DETECT = 2'b10
	} mse_mode_t;

endpackage

// [hdl/mse_slot_mem.sv]
// Purpose: one-indication store per memory, registered read
// Assumes: same clock as the monitor
// Notes: set wins over clear_ind; clear_det wins over set
`timescale 1ns/1ns
`default_nettype none
module mse_slot_mem
	import mse_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// Clock and control
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic watching,
	input wire logic clear_det,
	input wire logic clear_ind,
	// Upset reports from the memory
	input wire logic uncorr_ev,
	input wire logic corr_ev,
	input wire logic [ADDR_W-1:0] ev_addr,
	// Stored indication
	output logic [3:0] flags,
	output logic [ADDR_W-1:0] addr
);

	logic addr_held;
	logic addr_uncorr;

	always_ff @(posedge mclk)
	begin
		if (rst || (ce && clear_det))
		begin
			flags <= 4'h0;
			addr <= '0;
			addr_held <= 1'b0;
			addr_uncorr <= 1'b0;
		end
		else if (ce)
		begin
			if (clear_ind && !uncorr_ev && !corr_ev)
			begin
				flags <= 4'h0;
				addr_held <= 1'b0;
				addr_uncorr <= 1'b0;
			end
			// Uncorrectable has priority for the shared address
			if (uncorr_ev)
			begin
				if (watching && (!addr_held || !addr_uncorr))
				begin
					flags[INF_UNCORR_BIT] <= 1'b1;
					addr <= ev_addr;
					addr_held <= 1'b1;
					addr_uncorr <= 1'b1;
				end
				else
					flags[INF_UNCORR_LOST_BIT] <= 1'b1;
			end
			if (corr_ev)
			begin
				if (watching && !addr_held && !uncorr_ev)
				begin
					flags[INF_CORR_BIT] <= 1'b1;
					addr <= ev_addr;
					addr_held <= 1'b1;
				end
				else
					flags[INF_CORR_LOST_BIT] <= 1'b1;
			end
		end
	end

endmodule // mse_slot_mem
`default_nettype wire

// [hdl/mse_monitor.sv]
// Purpose: memory soft-error monitor with AXI4-Lite registers
// Assumes: memories report upsets as one-cycle pulses on reads
// Notes: register offsets are local choices
`timescale 1ns/1ns
`default_nettype none
module mse_monitor
	import mse_pkg::*;
#(
	parameter int NUM_MEM = 4,
	parameter int ADDR_W = 12,
	parameter int PCIE_FIRST = 3
)
(
	// Clock, enable, reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Upset reports, one bit per memory, pulsed on a read
	input wire logic [NUM_MEM-1:0] mem_uncorr,
	input wire logic [NUM_MEM-1:0] mem_corr,
	input wire logic [NUM_MEM*ADDR_W-1:0] mem_addr,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	initial
	begin
		if (NUM_MEM < 1 || NUM_MEM > 16 || ADDR_W < 1 || ADDR_W > 27)
			$error("mse_monitor: unsupported NUM_MEM or ADDR_W");
	end

	localparam int IDX_W = (NUM_MEM > 1) ? $clog2(NUM_MEM) : 1;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic wr_mapped;

	logic trigger;
	logic pcie_watch;
	logic [15:0] divider;
	logic [NUM_MEM-1:0] inj_uncorr;
	logic [NUM_MEM-1:0] inj_corr;

	mse_mode_t mode;
	logic busy;
	logic pending;
	logic [3:0] info_flags;
	logic [ADDR_W-1:0] info_addr;
	logic [IDX_W-1:0] info_index;

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFS_CONTROL) || (a == OFS_STATE) || (a == OFS_INFO) ||
			(a == OFS_INDEX) || (a == OFS_DIVIDER) || (a == OFS_INJECT);
	endfunction

	assign wr_mapped = is_mapped(aw_addr);

	// Address and data taken in either order
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end
		end
	end

	// Read path: one cycle to arready, data the cycle after
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (ce)
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				s_axi_rdata <= 32'h0000_0000;
				case (s_axi_araddr)
					OFS_CONTROL:
					begin
						s_axi_rdata[CTL_TRIGGER_BIT] <= trigger;
						s_axi_rdata[CTL_PCIE_WATCH_BIT] <= pcie_watch;
					end
					OFS_STATE:
					begin
						s_axi_rdata[ST_IDLE_BIT] <= (mode == MON_IDLE);
						s_axi_rdata[ST_DETECT_BIT] <= (mode == MON_DETECT);
						s_axi_rdata[ST_WATCHING_BIT] <= (mode == MON_WATCHING);
						s_axi_rdata[ST_BUSY_BIT] <= busy;
						s_axi_rdata[ST_PENDING_BIT] <= pending;
					end
					OFS_INFO:
					begin
						s_axi_rdata[INF_CORR_LOST_BIT:INF_UNCORR_BIT] <= info_flags;
						s_axi_rdata[INF_ADDR_LSB +: ADDR_W] <= info_addr;
					end
					OFS_INDEX: s_axi_rdata[IDX_W-1:0] <= info_index;
					OFS_DIVIDER: s_axi_rdata[15:0] <= divider;
					default: s_axi_rdata <= 32'h0000_0000;
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic step_done;
	logic wr_ctl;

	assign wr_ctl = do_write && aw_addr == OFS_CONTROL && w_strb[0];

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			trigger <= 1'b0;
			pcie_watch <= 1'b0;
			divider <= DIVIDER_RESET;
			inj_uncorr <= '0;
			inj_corr <= '0;
		end
		else if (ce)
		begin
			inj_uncorr <= '0;
			inj_corr <= '0;
			if (wr_ctl)
				pcie_watch <= w_data[CTL_PCIE_WATCH_BIT];
			// One-shot: cleared only once the next state is reached
			if (wr_ctl && w_data[CTL_TRIGGER_BIT])
				trigger <= 1'b1;
			else if (step_done)
				trigger <= 1'b0;
			if (do_write && aw_addr == OFS_DIVIDER)
			begin
				if (w_strb[0])
					divider[7:0] <= w_data[7:0];
				if (w_strb[1])
					divider[15:8] <= w_data[15:8];
			end
			// Test hook: software-raised upset pulses
			if (do_write && aw_addr == OFS_INJECT && w_strb[0])
			begin
				inj_uncorr <= w_data[NUM_MEM-1:0];
				inj_corr <= w_data[16 +: NUM_MEM];
			end
		end
	end

	// ------------------------------------------------------------
	// Memory slots
	// ------------------------------------------------------------
	logic [NUM_MEM-1:0] slot_valid;
	logic [NUM_MEM-1:0] clear_ind;
	logic clear_det;
	logic [3:0] slot_flags [NUM_MEM];
	logic [ADDR_W-1:0] slot_addr [NUM_MEM];

	for (genvar g = 0; g < NUM_MEM; g++)
	begin : g_slot
		logic watched;
		assign watched = (g < PCIE_FIRST) || pcie_watch;
		// Slots log only lost flags outside watching; delivery is gated below
		mse_slot_mem #(
			.ADDR_W(ADDR_W)
		) u_slot (
			.mclk(mclk),
			.rst(rst),
			.ce(ce),
			.watching(mode == MON_WATCHING),
			.clear_det(clear_det),
			.clear_ind(clear_ind[g]),
			.uncorr_ev(watched && (mem_uncorr[g] || inj_uncorr[g])),
			.corr_ev(watched && (mem_corr[g] || inj_corr[g])),
			.ev_addr(mem_addr[g*ADDR_W +: ADDR_W]),
			.flags(slot_flags[g]),
			.addr(slot_addr[g])
		);
		assign slot_valid[g] = |slot_flags[g];
	end

	// ------------------------------------------------------------
	// Monitor state machine
	// ------------------------------------------------------------
	logic [15:0] div_cnt;
	logic tick;
	logic first_done;
	logic [IDX_W-1:0] scan_idx;
	logic scan_found;

	// Transitions advance at the divided rate
	assign tick = (div_cnt == 16'h0000);

	always_ff @(posedge mclk)
	begin
		if (rst)
			div_cnt <= 16'h0000;
		else if (ce)
		begin
			if (!trigger)
				div_cnt <= 16'h0000;
			else
				div_cnt <= tick ? divider : div_cnt - 16'h0001;
		end
	end

	function automatic logic [IDX_W:0] next_valid(input logic [NUM_MEM-1:0] v, input int from);
		next_valid = '0;
		for (int i = NUM_MEM - 1; i >= 0; i--)
		begin
			if (v[i] && i >= from)
				next_valid = {1'b1, IDX_W'(i)};
		end
	endfunction

	logic [IDX_W:0] next_hit;
	assign next_hit = next_valid(slot_valid, (mode == MON_DETECT) ? int'(info_index) + 1 : 0);

	assign step_done = busy && tick && trigger;
	assign clear_det = step_done && !first_done;
	assign scan_found = next_hit[IDX_W];
	assign scan_idx = next_hit[IDX_W-1:0];

	always_ff @(posedge mclk)
	begin
		if (rst)
			busy <= 1'b0;
		else if (ce)
			busy <= trigger && !step_done;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			mode <= MON_IDLE;
			first_done <= 1'b0;
			info_flags <= 4'h0;
			info_addr <= '0;
			info_index <= '0;
			clear_ind <= '0;
		end
		else if (ce)
		begin
			clear_ind <= '0;
			if (step_done)
			begin
				case (mode)
					MON_IDLE:
					begin
						first_done <= 1'b1;
						if (!first_done || !scan_found)
							mode <= MON_WATCHING;
						else
						begin
							mode <= MON_DETECT;
							info_flags <= slot_flags[scan_idx];
							info_addr <= slot_addr[scan_idx];
							info_index <= scan_idx;
							clear_ind[scan_idx] <= 1'b1;
						end
					end
					MON_WATCHING: mode <= MON_IDLE;
					MON_DETECT:
					begin
						if (scan_found)
						begin
							info_flags <= slot_flags[scan_idx];
							info_addr <= slot_addr[scan_idx];
							info_index <= scan_idx;
							clear_ind[scan_idx] <= 1'b1;
						end
						else
						begin
							mode <= MON_WATCHING;
							info_flags <= 4'h0;
						end
					end
					default: mode <= MON_IDLE;
				endcase
			end
		end
	end

	// Pending flag set only while listening, held until detect runs out of slots; set wins over the clear
	always_ff @(posedge mclk)
	begin
		if (rst)
			pending <= 1'b0;
		else if (ce)
		begin
			if (mode == MON_WATCHING && |slot_valid)
				pending <= 1'b1;
			else if (mode == MON_DETECT && !scan_found && step_done)
				pending <= 1'b0;
		end
	end

endmodule // mse_monitor
`default_nettype wire

// [sim/mse_monitor_assertions.sv]
// Purpose: port checks for the soft-error monitor
// Assumes: ce held high by the bench
// Notes: bound to every monitor instance
`timescale 1ns/1ns
`default_nettype none
module mse_monitor_assertions
	import mse_pkg::*;
#(
	parameter int NUM_MEM = 4,
	parameter int ADDR_W = 12
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [7:0] rd_ofs;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_state_rd;
		s_axi_rvalid && rd_ofs == OFS_STATE;
	endsequence
	// Offset of the read in flight
	always_ff @(posedge mclk)
	begin
		if (s_axi_arvalid && s_axi_arready)
			rd_ofs <= s_axi_araddr;
	end
	a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write not answered");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data moved");
	a_state_onehot: assert property (s_state_rd |-> $onehot(s_axi_rdata[2:0]))
		else $error("state bits not one-hot");
	a_index_range: assert property (s_axi_rvalid && rd_ofs == OFS_INDEX |-> s_axi_rdata < NUM_MEM)
		else $error("index out of range");
	a_info_width: assert property (s_axi_rvalid && rd_ofs == OFS_INFO |-> (s_axi_rdata >> (4 + ADDR_W)) == 0)
		else $error("info spare bits set");
	a_reset_quiet: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
		else $error("bus busy after reset");
endmodule // mse_monitor_assertions
bind mse_monitor mse_monitor_assertions #(.NUM_MEM(NUM_MEM), .ADDR_W(ADDR_W)) u_chk (.mclk, .rst,
	.s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [sim/mse_mem_model.sv]
// Purpose: far-side memories that report upsets
// Assumes: one upset per call
// Notes: address lines scramble outside a pulse
`timescale 1ns/1ns
`default_nettype none
module mse_mem_model
#(
	parameter int NUM_MEM = 4,
	parameter int ADDR_W = 12
)
(
	// Clock
	input wire logic mclk,
	// Upset reports
	output logic [NUM_MEM-1:0] mem_uncorr,
	output logic [NUM_MEM-1:0] mem_corr,
	output logic [NUM_MEM*ADDR_W-1:0] mem_addr
);
	initial
	begin
		mem_uncorr = '0;
		mem_corr = '0;
		mem_addr = '0;
	end
	// Address valid only with the pulse, so stale values cannot pass
	task automatic upset(input int idx, input logic unc, input logic [ADDR_W-1:0] a);
		@(posedge mclk);
		mem_uncorr[idx] <= unc;
		mem_corr[idx] <= !unc;
		mem_addr[idx*ADDR_W+:ADDR_W] <= a;
		@(posedge mclk);
		mem_uncorr <= '0;
		mem_corr <= '0;
		mem_addr <= ~mem_addr;
	endtask
endmodule // mse_mem_model
`default_nettype wire

// [sim/tb_mse_monitor.sv]
// Purpose: bench for the soft-error monitor
// Assumes: divider programmed before the first step
// Notes: xorshift picks upset memories and addresses
`timescale 1ns/1ns
`default_nettype none
module tb_mse_monitor
	import mse_pkg::*;
;
	logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, unc;
	logic [3:0] mem_uncorr, mem_corr, s_axi_wstrb;
	logic [47:0] mem_addr;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [11:0] a;
	int miscompares, n_tests, idx;
	mse_monitor dut (.mclk, .rst, .ce(1'b1), .mem_uncorr, .mem_corr, .mem_addr, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	mse_mem_model model (.mclk, .mem_uncorr, .mem_corr, .mem_addr);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [4:0] st_exp(input int b, input logic p);
		return 5'(1 << b) | {p, 4'h0};
	endfunction
	function automatic logic [31:0] inf_exp(input logic [3:0] fl, input logic [11:0] ad);
		return {16'h0, ad, fl};
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		while (!s_axi_bvalid && n < 99);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] ad);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		while (!s_axi_rvalid && n < 99);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic stc(input int b, input logic p, input logic [4:0] m);
		axr(OFS_STATE);
		chk("state", 32'(st_exp(b, p)), 32'(rd[4:0] & m));
	endtask
	task automatic step();
		int n;
		n = 0;
		axw(OFS_CONTROL, 32'h0000_0001);
		axr(OFS_STATE);
		chk("busy", 32'h1, 32'(rd[ST_BUSY_BIT]));
		do
		begin
			axr(OFS_CONTROL);
			n++;
		end
		while (rd[CTL_TRIGGER_BIT] !== 1'b0 && n < 40);
		chk("trigger", 32'h0, 32'(rd[CTL_TRIGGER_BIT]));
	endtask
	task automatic det(input int i, input logic [31:0] e, input logic [31:0] mk);
		step();
		stc(ST_DETECT_BIT, 1'b0, 5'h0F);
		axr(OFS_INDEX);
		chk("index", i, rd);
		axr(OFS_INFO);
		chk("info", e, rd & mk);
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial
	begin
		#200000;
		miscompares++;
		close_out();
	end
	initial
	begin
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		seed = 32'd95;
		miscompares = 0;
		n_tests = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		stc(ST_IDLE_BIT, 1'b0, 5'h1F);
		axr(OFS_DIVIDER);
		chk("divider", 32'h0000_00FF, rd);
		axr(8'h18);
		chk("bad addr", 32'(RESP_SLVERR), 32'(rs));
		axw(OFS_DIVIDER, 32'h0000_0020);
		model.upset(1, 1'b1, 12'h5A5);
		stc(ST_IDLE_BIT, 1'b0, 5'h1F);
		step();
		stc(ST_WATCHING_BIT, 1'b0, 5'h1F);
		$display("test reset done");
		for (int i = 0; i < 4; i++)
		begin
			void'(xs());
			idx = int'(seed[1:0]) % 3;
			a = seed[15:4];
			unc = seed[2];
			model.upset(idx, unc, a);
			stc(ST_WATCHING_BIT, 1'b1, 5'h1F);
			step();
			det(idx, inf_exp(unc ? 4'h1 : 4'h4, a), 32'hFFFF_FFFF);
			step();
			stc(ST_WATCHING_BIT, 1'b0, 5'h1F);
		end
		$display("test random done");
		model.upset(2, 1'b1, 12'h3C1);
		model.upset(2, 1'b0, 12'h0F0);
		model.upset(0, 1'b0, 12'h7E2);
		model.upset(0, 1'b0, 12'h111);
		step();
		stc(ST_IDLE_BIT, 1'b0, 5'h0F);
		model.upset(1, 1'b1, 12'h222);
		det(0, inf_exp(4'hC, 12'h7E2), 32'hFFFF_FFFF);
		det(1, 32'h2, 32'h2);
		det(2, inf_exp(4'h9, 12'h3C1), 32'hFFFF_FFFF);
		step();
		stc(ST_WATCHING_BIT, 1'b0, 5'h1F);
		$display("test readout done");
		// Gated memories stay silent until the watch bit is set
		model.upset(3, 1'b1, 12'h456);
		stc(ST_WATCHING_BIT, 1'b0, 5'h1F);
		axw(OFS_CONTROL, 32'h0000_0002);
		axr(OFS_CONTROL);
		chk("pcie watch", 32'h2, rd);
		axw(OFS_INJECT, 32'h0000_0008);
		stc(ST_WATCHING_BIT, 1'b1, 5'h1F);
		$display("test pcie watch done");
		close_out();
	end
endmodule // tb_mse_monitor
`default_nettype wire
